/* File: logic/lpr_sched.sv */
// Device-side bank and refresh bookkeeping for the SDRAM command decoder.
// Assumes command/address already captured on the rising edge in this clock
// domain, with read/write auto-precharge bits taken from the falling edge.
//
// What this block does
// - Reads or writes to other banks may follow auto-precharge access seamlessly.
// - Bank precharge period runs tRP from the latest precharge hitting it.
// - Refresh decodes CS low, CA0 low, CA1 low, CA2 high; CA3 picks all-bank.
// - Per-bank refresh exists only on eight-bank devices.
// - Internal counter picks per-bank refresh bank, round robin zero to seven.
// - Counter clears on RESET command, self-refresh exit and all-bank refresh.
// - Only the refreshed bank is busy; it returns idle when refresh ends.
// - Bank comes from CA7 to CA9; the all-bank flag on CA4 overrides.
// - Read or write auto-precharges when falling-edge CA0 is high.
`timescale 1ns/1ps
`default_nettype none
`include "lpr_cfg.svh"
module lpr_sched
  import lpr_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_cs_n,
  input  wire logic [9:0]               i_ca_rise,
  input  wire logic                     i_ca0_fall,
  input  wire logic                     i_cmd_rd,
  input  wire logic                     i_cmd_wr,
  input  wire logic                     i_cmd_act,
  input  wire logic                     i_cmd_pre,
  input  wire logic                     i_reset_cmd,
  input  wire logic                     i_sr_exit,
  input  wire logic                     i_ap_start,
  input  wire logic [`LPR_BANK_W-1:0]   i_ap_bank,
  output logic                          o_refresh,
  output logic                          o_refresh_all,
  output logic [`LPR_BANK_W-1:0]        o_refresh_bank,
  output logic [`LPR_BANK_W-1:0]        o_next_ref_bank,
  output logic [`LPR_BANKS-1:0]         o_bank_open,
  output logic [`LPR_BANKS-1:0]         o_bank_busy,
  output logic [`LPR_BANKS-1:0]         o_bank_ap_pending,
  output logic [`LPR_BANKS-1:0]         o_precharge
);
  lpr_state_t             st;
  lpr_state_t             next_st;
  logic                   is_ref;
  logic                   is_ref_all;
  logic                   pre_all;
  logic [`LPR_BANK_W-1:0] cmd_bank;
  logic                   ap_bit;

  always_comb begin
    is_ref     = !i_cs_n && !i_ca_rise[0] && !i_ca_rise[1] && i_ca_rise[2];
    is_ref_all = is_ref && i_ca_rise[`LPR_CA_REF_AB];
    pre_all    = i_ca_rise[`LPR_CA_AB];
    cmd_bank   = i_ca_rise[`LPR_CA_BA_HI:`LPR_CA_BA_LO];
    ap_bit     = i_ca0_fall;
  end

  always_comb begin
    next_st            = st;
    next_st.ref_pulse  = 1'b0;
    next_st.ref_all    = 1'b0;
    next_st.pre_pulse  = '0;
    // Timers count down; a bank leaves the busy state when its timer expires.
    for (int b = 0; b < `LPR_BANKS; b++) begin
      if (st.busy_tmr[b] != '0) begin
        next_st.busy_tmr[b] = st.busy_tmr[b] - `LPR_TMR_W'(1);
        if (st.busy_tmr[b] == `LPR_TMR_W'(1)) begin
          next_st.refreshing[b] = 1'b0;
        end
      end
    end
    if (i_ap_start) begin
      // Auto-precharge begins: the bank closes and tRPpb runs from here.
      next_st.open[i_ap_bank]     = 1'b0;
      next_st.auto_pre[i_ap_bank] = 1'b0;
      next_st.busy_tmr[i_ap_bank] = `LPR_TMR_W'(`LPR_TRPPB_CYC);
      next_st.pre_pulse[i_ap_bank] = 1'b1;
    end
    if (i_cmd_pre) begin
      for (int b = 0; b < `LPR_BANKS; b++) begin
        if (pre_all || cmd_bank == `LPR_BANK_W'(b)) begin
          // The latest precharge restarts the period, whatever came before.
          next_st.open[b]      = 1'b0;
          next_st.pre_pulse[b] = 1'b1;
          next_st.busy_tmr[b] = pre_all ? `LPR_TMR_W'(`LPR_TRPAB_CYC)
                                        : `LPR_TMR_W'(`LPR_TRPPB_CYC);
        end
      end
    end
    if (i_cmd_act) begin
      next_st.open[cmd_bank] = 1'b1;
    end
    // Arming is per bank only, so accesses to other banks are never held off.
    if ((i_cmd_rd || i_cmd_wr) && ap_bit) begin
      next_st.auto_pre[cmd_bank] = 1'b1;
    end
    if (is_ref_all) begin
      next_st.ref_bank  = '0;
      next_st.ref_pulse = 1'b1;
      next_st.ref_all   = 1'b1;
      for (int b = 0; b < `LPR_BANKS; b++) begin
        next_st.refreshing[b] = 1'b1;
        next_st.busy_tmr[b]   = `LPR_TMR_W'(`LPR_TRFCAB_CYC);
      end
    end else if (is_ref) begin
      // Only the counter's bank is refreshed; others stay usable.
      next_st.ref_target              = st.ref_bank;
      next_st.ref_bank                = st.ref_bank + `LPR_BANK_W'(1);
      next_st.ref_pulse               = 1'b1;
      next_st.refreshing[st.ref_bank] = 1'b1;
      next_st.busy_tmr[st.ref_bank]   = `LPR_TMR_W'(`LPR_TRFCPB_CYC);
    end
    if (i_reset_cmd || i_sr_exit) begin
      next_st.ref_bank = '0;
    end
    if (i_reset_cmd) begin
      next_st.open       = '0;
      next_st.auto_pre   = '0;
      next_st.refreshing = '0;
      next_st.busy_tmr   = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    o_refresh         = st.ref_pulse;
    o_refresh_all     = st.ref_all;
    o_refresh_bank    = st.ref_target;
    o_next_ref_bank   = st.ref_bank;
    o_bank_open       = st.open;
    o_bank_ap_pending = st.auto_pre;
    o_precharge       = st.pre_pulse;
  end

  // A bank is busy while refreshing or while its precharge timer runs.
  for (genvar g = 0; g < `LPR_BANKS; g++) begin : g_busy
    assign o_bank_busy[g] = st.refreshing[g] || (st.busy_tmr[g] != '0);
  end
endmodule
`default_nettype wire

/* File: shared/lpr_cfg.svh */
// Constants for the refresh and precharge scheduling logic of the SDRAM core.
// Assumes a 125 MHz core clock and an eight-bank device.
`ifndef LPR_CFG_SVH
`define LPR_CFG_SVH
`define LPR_CLK_PERIOD_PS 8000
`define LPR_BANKS         8
`define LPR_BANK_W        3
// Row precharge and refresh cycle times in picoseconds; plain defaults.
`define LPR_TRPPB_PS      18000
`define LPR_TRPAB_PS      21000
`define LPR_TRFCPB_PS     60000
`define LPR_TRFCAB_PS     130000
// Times rounded up to whole clocks, never less than one.
`define LPR_CYC(ps) ((((ps) + `LPR_CLK_PERIOD_PS - 1) / `LPR_CLK_PERIOD_PS) < 1 ? 1 : \
  (((ps) + `LPR_CLK_PERIOD_PS - 1) / `LPR_CLK_PERIOD_PS))
`define LPR_TRPPB_CYC     `LPR_CYC(`LPR_TRPPB_PS)
`define LPR_TRPAB_CYC     `LPR_CYC(`LPR_TRPAB_PS)
`define LPR_TRFCPB_CYC    `LPR_CYC(`LPR_TRFCPB_PS)
`define LPR_TRFCAB_CYC    `LPR_CYC(`LPR_TRFCAB_PS)
`define LPR_TMR_W         8
// Command/address bit positions on the rising edge.
`define LPR_CA_AB         4
`define LPR_CA_BA_LO      7
`define LPR_CA_BA_HI      9
`define LPR_CA_REF_AB     3
`endif

/* File: shared/lpr_pkg.sv */
// Types for the refresh and precharge scheduling logic.
// Assumes lpr_cfg.svh for all figures.
`include "lpr_cfg.svh"
package lpr_pkg;
  typedef enum logic [2:0] {
    LPR_CMD_NONE,
    LPR_CMD_PRE,
    LPR_CMD_REF,
    LPR_CMD_RD,
    LPR_CMD_WR,
    LPR_CMD_ACT
  } lpr_cmd_t;

  typedef struct packed {
    logic [`LPR_BANK_W-1:0]                    ref_bank;
    logic [`LPR_BANKS-1:0]                     open;
    logic [`LPR_BANKS-1:0]                     auto_pre;
    logic [`LPR_BANKS-1:0]                     refreshing;
    logic [`LPR_BANKS-1:0][`LPR_TMR_W-1:0]     busy_tmr;
    logic                                      ref_pulse;
    logic                                      ref_all;
    logic [`LPR_BANK_W-1:0]                    ref_target;
    logic [`LPR_BANKS-1:0]                     pre_pulse;
  } lpr_state_t;
endpackage

/* File: tb/lpr_ctrl_model.sv */
// Memory controller model that issues commands to the scheduler.
// Assumes the bench calls issue once per command, in a legal order.
`timescale 1ns/1ps
`default_nettype none
module lpr_ctrl_model (
  input  wire logic       i_clk,
  output logic            o_cs_n,
  output logic [9:0]      o_ca,
  output logic            o_ca0_fall,
  output logic [6:0]      o_pulse
);
  initial begin
    o_cs_n = 1'b1;
    o_ca = 10'h3FF;
    o_ca0_fall = 1'b0;
    o_pulse = 7'h00;
  end
  // Pulses are {rd, wr, act, pre, reset, sr exit, ap start}.
  task automatic issue(input logic cs, input logic [9:0] ca, input logic f,
                       input logic [6:0] p, input int gap);
    // The caller's gap keeps every spacing
    // in whole clocks rounded up from the timings.
    repeat (gap) @(posedge i_clk);
    o_cs_n <= cs;
    o_ca <= ca;
    o_ca0_fall <= f;
    o_pulse <= p;
    @(posedge i_clk);
    // An idle bus shows the inverse so no stale value can pass as a command.
    o_cs_n <= 1'b1;
    o_ca <= ~ca;
    o_ca0_fall <= ~f;
    o_pulse <= 7'h00;
  endtask
endmodule
`default_nettype wire

/* File: tb/lpr_sched_props.sv */
// Checker for the scheduler ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lpr_sched_props (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_cs_n,
  input wire logic [9:0] i_ca_rise,
  input wire logic       i_ca0_fall,
  input wire logic       i_cmd_rd,
  input wire logic       i_cmd_pre,
  input wire logic       i_reset_cmd,
  input wire logic       i_sr_exit,
  input wire logic       o_refresh,
  input wire logic       o_refresh_all,
  input wire logic [2:0] o_refresh_bank,
  input wire logic [2:0] o_next_ref_bank,
  input wire logic [7:0] o_bank_busy,
  input wire logic [7:0] o_bank_ap_pending,
  input wire logic [7:0] o_precharge
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic clr;
  logic ref_d;
  assign clr = i_reset_cmd || i_sr_exit;
  assign ref_d = !i_cs_n && i_ca_rise[2:0] == 3'h4 && !clr;
  sequence s_pb; ref_d && !i_ca_rise[3]; endsequence
  sequence s_ab; ref_d && i_ca_rise[3]; endsequence
  a_ref_pulse: assert property (ref_d |=> o_refresh && o_refresh_all == $past(i_ca_rise[3]))
    else $error("refresh decode missed");
  a_rr_step: assert property (s_pb |=> o_next_ref_bank == $past(o_next_ref_bank) + 3'h1)
    else $error("bank counter did not step");
  a_pb_target: assert property (s_pb |=> o_refresh_bank == $past(o_next_ref_bank))
    else $error("wrong refresh bank");
  a_ab_clear: assert property (s_ab |=> o_next_ref_bank == 3'h0)
    else $error("all-bank refresh kept counter");
  a_cmd_clear: assert property (clr |=> o_next_ref_bank == 3'h0)
    else $error("counter not cleared");
  a_pb_busy: assert property (s_pb |=> (o_bank_busy[o_refresh_bank]) [*8])
    else $error("refreshed bank not busy");
  a_ab_busy: assert property (s_ab |=> (&o_bank_busy) [*8])
    else $error("banks not busy in refresh");
  a_pre_bank: assert property (i_cmd_pre && !clr |=> o_precharge == ($past(i_ca_rise[4]) ?
    8'hFF : 8'h01 << $past(i_ca_rise[9:7]))) else $error("wrong precharge bank");
  a_ap_arm: assert property (i_cmd_rd && i_ca0_fall && !clr |=> o_bank_ap_pending[$past(i_ca_rise[9:7])])
    else $error("auto-precharge not armed");
endmodule
bind lpr_sched lpr_sched_props i_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_cs_n(i_cs_n), .i_ca_rise(i_ca_rise), .i_ca0_fall(i_ca0_fall), .i_cmd_rd(i_cmd_rd),
  .i_cmd_pre(i_cmd_pre), .i_reset_cmd(i_reset_cmd), .i_sr_exit(i_sr_exit),
  .o_refresh(o_refresh), .o_refresh_all(o_refresh_all), .o_refresh_bank(o_refresh_bank),
  .o_next_ref_bank(o_next_ref_bank), .o_bank_busy(o_bank_busy),
  .o_bank_ap_pending(o_bank_ap_pending), .o_precharge(o_precharge));
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the scheduler.
// Assumes the controller model paces commands; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cs_n, f, rf, ra;
  logic [9:0] ca;
  logic [6:0] p;
  logic [2:0] rb, nb;
  logic [7:0] op, busy, ap, pre;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         cyc = 0;
  always #4 clk = ~clk;
  lpr_ctrl_model i_lpr_ctrl_model (.i_clk(clk), .o_cs_n(cs_n), .o_ca(ca), .o_ca0_fall(f),
    .o_pulse(p));
  lpr_sched i_lpr_sched (.i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_ca_rise(ca),
    .i_ca0_fall(f), .i_cmd_rd(p[6]), .i_cmd_wr(p[5]), .i_cmd_act(p[4]), .i_cmd_pre(p[3]),
    .i_reset_cmd(p[2]), .i_sr_exit(p[1]), .i_ap_start(p[0]), .i_ap_bank(ca[9:7]),
    .o_refresh(rf), .o_refresh_all(ra), .o_refresh_bank(rb), .o_next_ref_bank(nb),
    .o_bank_open(op), .o_bank_busy(busy), .o_bank_ap_pending(ap), .o_precharge(pre));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic c, input logic [9:0] a, input logic fb, input logic [6:0] q,
                     input int g);
    i_lpr_ctrl_model.issue(c, a, fb, q, g);
    #1;
  endtask
  task automatic t_round_robin;
    for (int i = 1; i <= 9; i++) begin
      cmd(1'b0, 10'h004, 1'b0, 7'h00, 8);
      chk({7'h00, rf}, 8'h01);
      chk({5'h00, nb}, 8'(i % 8));
      chk({5'h00, rb}, 8'((i - 1) % 8));
      chk(busy, 8'h01 << ((i - 1) % 8));
    end
  endtask
  task automatic t_clears;
    cmd(1'b0, 10'h00C, 1'b0, 7'h00, 8);
    chk({6'h00, ra, rf}, 8'h03);
    chk({5'h00, nb}, 8'h00);
    chk(busy, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      cmd(1'b0, 10'h004, 1'b0, 7'h00, 17);
      chk({5'h00, nb}, 8'h01);
      cmd(1'b1, 10'h000, 1'b0, 7'h04 >> k, 8);
      chk({5'h00, nb}, 8'h00);
    end
  endtask
  task automatic t_precharge;
    cmd(1'b1, 10'h280, 1'b0, 7'h10, 17);
    chk(op, 8'h20);
    cmd(1'b1, 10'h280, 1'b0, 7'h08, 8);
    chk(pre, 8'h20);
    chk(busy, 8'h20);
    cmd(1'b1, 10'h010, 1'b0, 7'h08, 0);
    chk(pre, 8'hFF);
    chk(busy, 8'hFF);
    cmd(1'b1, 10'h100, 1'b0, 7'h10, 8);
    cmd(1'b1, 10'h100, 1'b1, 7'h40, 8);
    chk(ap, 8'h04);
    cmd(1'b1, 10'h100, 1'b0, 7'h01, 8);
    chk(ap, 8'h00);
    chk(op, 8'h00);
    chk(pre, 8'h04);
    chk(busy, 8'h04);
    cmd(1'b1, 10'h000, 1'b1, 7'h20, 8);
    chk(ap, 8'h01);
    chk(pre, 8'h00);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_round_robin();
    t_clears();
    t_precharge();
    print_verdict();
  end
endmodule
`default_nettype wire
